// file: rtl/dfc_pkg.sv
package dfc_pkg;

  // Register index on the device's own register port
  localparam logic [2:0] DEV_IDX_AREA = 3'h0; // area_select_reg
  localparam logic [2:0] DEV_IDX_APL  = 3'h1; // addr_ptr_low
  localparam logic [2:0] DEV_IDX_APH  = 3'h2; // addr_ptr_high
  localparam logic [2:0] DEV_IDX_EDL  = 3'h3; // end_addr_low
  localparam logic [2:0] DEV_IDX_EDH  = 3'h4; // end_addr_high
  localparam logic [2:0] DEV_IDX_CMD  = 3'h5; // seq_command_reg

  // Values written to the device
  localparam int         AREA_SEL_BIT  = 0;      // extra_area_sel position
  localparam logic [7:0] AREA_USER     = 8'h00;  // Code/data flash area
  localparam int         LAUNCH_BIT    = 7;      // seq_launch position
  localparam int         MODE_CHG_BIT  = 3;      // mode_change position
  localparam logic [2:0] OP_BLANK      = 3'h3;   // seq_op_code, blank check
  localparam logic [2:0] OP_VERIFY     = 3'h2;   // seq_op_code, internal verify
  localparam logic [7:0] CMD_BLANK     = 8'h8B;  // Full blank-check command
  localparam logic [7:0] CMD_VERIFY    = 8'h8A;  // Full verify command
  localparam logic [31:0] ADDR_MASK    = 32'h00FFFFFF; // Upper 8 bits forced off

  // Controller's own Avalon registers (byte offsets)
  localparam logic [3:0] CSR_CTRL   = 4'h0;
  localparam logic [3:0] CSR_STATUS = 4'h4;
  localparam logic [3:0] CSR_START  = 4'h8;
  localparam logic [3:0] CSR_LENGTH = 4'hC;

  // Control fields
  localparam int CTRL_GO_BIT  = 0; // Write 1 to launch
  localparam int CTRL_OP_BIT  = 1; // 0 blank check, 1 internal verify
  localparam int CTRL_ARM_BIT = 2; // Write 1 after programming an area

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT  = 2;
  localparam int STAT_FAIL_BIT = 3;
  localparam int STAT_CODE_LSB = 4;
  localparam int STAT_ARM_BIT  = 8;

  // Cycles before the device's busy flag is trusted after launch
  localparam logic [3:0] SETTLE_CYC = 4'h2;

  // Reasons a launch was refused
  typedef enum logic [2:0] {
    ERR_NONE,
    ERR_DISABLED,
    ERR_MODE,
    ERR_BUSY,
    ERR_RANGE,
    ERR_REVERIFY
  } dfc_err_t;

endpackage

// file: rtl/dfc_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dfc_wr_if;
  logic        req;  // Hold while a device write is wanted
  logic [2:0]  idx;  // Device register index
  logic [15:0] data; // Value to write
  logic        ack;  // One-cycle pulse: write issued

  modport ctl (output req, output idx, output data, input ack);
  modport drv (input req, input idx, input data, output ack);
endinterface
`default_nettype wire

// file: rtl/dfc_dev_writer.sv
`timescale 1ns/1ps
`default_nettype none
module dfc_dev_writer (
  input  wire logic   clk_i,       // 20 MHz clock
  input  wire logic   rst_n_i,     // Sync reset, active low
  dfc_wr_if.drv       w,           // Requests from the sequencer
  output logic        dev_wr_o,    // Device register write strobe
  output logic [2:0]  dev_addr_o,  // Device register index
  output logic [15:0] dev_wdata_o  // Device register data
);
  logic        wr_q, wr_d;
  logic [2:0]  addr_q, addr_d;
  logic [15:0] data_q, data_d;

  // One strobe per request; the cycle after an ack is skipped so the
  // requester has time to move on before a repeat could go out
  always_comb
  begin
    wr_d   = w.req && !wr_q;
    addr_d = addr_q;
    data_d = data_q;
    if (w.req && !wr_q)
    begin
      addr_d = w.idx;
      data_d = w.data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_q   <= 1'b0;
      addr_q <= 3'h0;
      data_q <= 16'h0000;
    end
    else
    begin
      wr_q   <= wr_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign w.ack       = wr_q;
  assign dev_wr_o    = wr_q;
  assign dev_addr_o  = addr_q;
  assign dev_wdata_o = data_q;

  strobe_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_q |=> !wr_q)
    else $error("device write strobe lasted two cycles");
endmodule
`default_nettype wire

// file: rtl/dfc_csr.sv
`timescale 1ns/1ps
`default_nettype none
module dfc_csr (
  input  wire logic        clk_i,             // 20 MHz clock
  input  wire logic        rst_n_i,           // Sync reset, active low
  input  wire logic [3:0]  avs_address_i,     // Byte address
  input  wire logic        avs_read_i,        // Read request
  input  wire logic        avs_write_i,       // Write request
  input  wire logic [31:0] avs_writedata_i,   // Write data
  output logic      [31:0] avs_readdata_o,    // Read data
  output logic             avs_waitrequest_o, // Low for one cycle to answer
  input  wire logic [31:0] status_i,          // Live status word
  output logic             go_o,              // Launch pulse
  output logic             op_verify_o,       // Operation of that launch
  output logic             arm_o,             // Area-written pulse
  output logic             clr_o,             // Clear done/error pulse
  output logic      [31:0] start_o,           // Start address
  output logic      [15:0] length_o           // Byte count
);
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] start_q, start_d;
  logic [15:0] len_q, len_d;
  logic        go_q, go_d, op_q, op_d, arm_q, arm_d, clr_q, clr_d;
  logic        take;

  // A request is taken at the edge where waitrequest is low
  assign take = (avs_read_i || avs_write_i) && !wait_q;

  // Answer every request one cycle after it appears
  always_comb
  begin
    wait_d  = !((avs_read_i || avs_write_i) && wait_q);
    rdata_d = rdata_q;
    start_d = start_q;
    len_d   = len_q;
    go_d    = 1'b0;
    op_d    = op_q;
    arm_d   = 1'b0;
    clr_d   = 1'b0;
    if (avs_read_i && wait_q)
    begin
      case (avs_address_i)
        dfc_pkg::CSR_CTRL:   rdata_d = {31'h00000000, op_q} << dfc_pkg::CTRL_OP_BIT;
        dfc_pkg::CSR_STATUS: rdata_d = status_i;
        dfc_pkg::CSR_START:  rdata_d = start_q;
        dfc_pkg::CSR_LENGTH: rdata_d = {16'h0000, len_q};
        default:             rdata_d = 32'h00000000; // Unmapped reads zero
      endcase
    end
    if (take && avs_write_i)
    begin
      case (avs_address_i)
        dfc_pkg::CSR_CTRL:
        begin
          go_d  = avs_writedata_i[dfc_pkg::CTRL_GO_BIT];
          op_d  = avs_writedata_i[dfc_pkg::CTRL_OP_BIT];
          arm_d = avs_writedata_i[dfc_pkg::CTRL_ARM_BIT];
        end
        dfc_pkg::CSR_STATUS: clr_d   = 1'b1;
        dfc_pkg::CSR_START:  start_d = avs_writedata_i;
        dfc_pkg::CSR_LENGTH: len_d   = avs_writedata_i[15:0];
        default:             clr_d   = 1'b0; // Unmapped writes ignored
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
      start_q <= 32'h00000000;
      len_q   <= 16'h0000;
      go_q    <= 1'b0;
      op_q    <= 1'b0;
      arm_q   <= 1'b0;
      clr_q   <= 1'b0;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      len_q   <= len_d;
      go_q    <= go_d;
      op_q    <= op_d;
      arm_q   <= arm_d;
      clr_q   <= clr_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign go_o              = go_q;
  assign op_verify_o       = op_q;
  assign arm_o             = arm_q;
  assign clr_o             = clr_q;
  assign start_o           = start_q;
  assign length_o          = len_q;

  answer_one_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && wait_q |=> !wait_q ##1 wait_q)
    else $error("waitrequest did not answer in one cycle");
endmodule
`default_nettype wire

// file: rtl/dfc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dfc_ctrl #(
  parameter logic [23:0] DF_BASE    = 24'h100000, // First data flash byte
  parameter logic [23:0] DF_SIZE    = 24'h008000, // Data flash bytes
  parameter logic [23:0] BLOCK_SIZE = 24'h000400  // Bytes per block, power of two
) (
  input  wire logic        clk_i,             // 20 MHz clock
  input  wire logic        rst_n_i,           // Sync reset, active low
  input  wire logic [3:0]  avs_address_i,     // Avalon byte address
  input  wire logic        avs_read_i,        // Avalon read
  input  wire logic        avs_write_i,       // Avalon write
  input  wire logic [31:0] avs_writedata_i,   // Avalon write data
  output logic      [31:0] avs_readdata_o,    // Avalon read data
  output logic             avs_waitrequest_o, // Avalon waitrequest
  output logic             dev_wr_o,          // Device register write strobe
  output logic      [2:0]  dev_addr_o,        // Device register index
  output logic      [15:0] dev_wdata_o,       // Device register data
  input  wire logic        dflash_access_en_i,// Device data flash access enable
  input  wire logic        dev_prog_mode_i,   // Device in data flash programming mode
  input  wire logic        dev_seq_busy_i,    // Code/data flash sequencer busy
  input  wire logic        dev_extra_busy_i,  // Extra-area sequencer busy
  input  wire logic        dev_seq_err_i      // Device result, valid when idle
);

  // Refuse geometries the range check cannot handle
  if (BLOCK_SIZE == 24'h000000 || (BLOCK_SIZE & (BLOCK_SIZE - 24'h000001)) != 24'h000000
      || DF_SIZE == 24'h000000)
  begin : g_bad_geom
    $error("BLOCK_SIZE must be a nonzero power of two and DF_SIZE nonzero");
  end

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CHECK,
    ST_AREA,
    ST_APL,
    ST_APH,
    ST_EDL,
    ST_EDH,
    ST_CMD,
    ST_SETTLE,
    ST_POLL
  } dfc_state_t;

  dfc_wr_if wr ();

  logic        go, op_verify, arm, clr;
  logic [31:0] start_reg;
  logic [15:0] len_reg;
  logic [31:0] status;

  dfc_csr u_csr (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .status_i          (status),
    .go_o              (go),
    .op_verify_o       (op_verify),
    .arm_o             (arm),
    .clr_o             (clr),
    .start_o           (start_reg),
    .length_o          (len_reg)
  );

  dfc_dev_writer u_writer (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .w           (wr),
    .dev_wr_o    (dev_wr_o),
    .dev_addr_o  (dev_addr_o),
    .dev_wdata_o (dev_wdata_o)
  );

  // Offset from DF_BASE of the start of the block holding a data flash address
  function automatic logic [23:0] block_of(input logic [23:0] a);
    block_of = (a - DF_BASE) & ~(BLOCK_SIZE - 24'h000001);
  endfunction

  dfc_state_t        state_q, state_d;
  logic [23:0]       start_q, start_d;
  logic [23:0]       end_q, end_d;
  logic              op_q, op_d;
  logic              armed_q, armed_d;
  logic              done_q, done_d;
  logic              fail_q, fail_d;
  dfc_pkg::dfc_err_t err_q, err_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [23:0]       last_byte;
  logic              range_bad;

  // Upper 8 bits of the start are dropped before anything else
  assign last_byte = end_q - 24'h000001;
  assign range_bad = (len_reg == 16'h0000)
                  || (start_q < DF_BASE)
                  || (last_byte >= DF_BASE + DF_SIZE)
                  || (block_of(start_q) != block_of(last_byte));

  // Status word seen by software
  assign status = {23'h000000, armed_q, 1'b0, err_q, fail_q,
                   (err_q != dfc_pkg::ERR_NONE), done_q, (state_q != ST_IDLE)};

  // Device write request by state
  always_comb
  begin
    wr.req  = 1'b1;
    wr.idx  = dfc_pkg::DEV_IDX_AREA;
    wr.data = 16'h0000;
    case (state_q)
      ST_AREA: wr.data = {8'h00, dfc_pkg::AREA_USER};
      ST_APL:
      begin
        wr.idx  = dfc_pkg::DEV_IDX_APL;
        wr.data = start_q[15:0];
      end
      ST_APH:
      begin
        wr.idx  = dfc_pkg::DEV_IDX_APH;
        wr.data = {8'h00, start_q[23:16]};
      end
      ST_EDL:
      begin
        wr.idx  = dfc_pkg::DEV_IDX_EDL;
        wr.data = end_q[15:0];
      end
      ST_EDH:
      begin
        wr.idx  = dfc_pkg::DEV_IDX_EDH;
        wr.data = {8'h00, end_q[23:16]};
      end
      ST_CMD:
      begin
        wr.idx  = dfc_pkg::DEV_IDX_CMD;
        wr.data = {8'h00, op_q ? dfc_pkg::CMD_VERIFY : dfc_pkg::CMD_BLANK};
      end
      default: wr.req = 1'b0;
    endcase
  end

  // Sequencer: check, program the device, launch, wait for the end
  always_comb
  begin
    state_d = state_q;
    start_d = start_q;
    end_d   = end_q;
    op_d    = op_q;
    armed_d = armed_q || arm;
    done_d  = done_q;
    fail_d  = fail_q;
    err_d   = err_q;
    cnt_d   = cnt_q;
    // Software clear first so a same-cycle completion still sets done
    if (clr)
    begin
      done_d = 1'b0;
      fail_d = 1'b0;
      err_d  = dfc_pkg::ERR_NONE;
    end
    case (state_q)
      ST_IDLE:
      begin
        if (go)
        begin
          start_d = start_reg[23:0] & dfc_pkg::ADDR_MASK[23:0];
          end_d   = start_reg[23:0] + {8'h00, len_reg};
          op_d    = op_verify;
          done_d  = 1'b0;
          fail_d  = 1'b0;
          err_d   = dfc_pkg::ERR_NONE;
          state_d = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        state_d = ST_IDLE;
        done_d  = 1'b1;
        if (!dflash_access_en_i)
        begin
          err_d = dfc_pkg::ERR_DISABLED;
        end
        else if (!dev_prog_mode_i)
        begin
          err_d = dfc_pkg::ERR_MODE;
        end
        else if (dev_seq_busy_i || dev_extra_busy_i)
        begin
          err_d = dfc_pkg::ERR_BUSY;
        end
        else if (range_bad)
        begin
          err_d = dfc_pkg::ERR_RANGE;
        end
        else if (op_q && !armed_q)
        begin
          err_d = dfc_pkg::ERR_REVERIFY;
        end
        else
        begin
          done_d  = 1'b0;
          state_d = ST_AREA;
          if (op_q)
          begin
            armed_d = 1'b0;
          end
        end
      end
      ST_AREA: state_d = wr.ack ? ST_APL : ST_AREA;
      ST_APL:  state_d = wr.ack ? ST_APH : ST_APL;
      ST_APH:  state_d = wr.ack ? ST_EDL : ST_APH;
      ST_EDL:  state_d = wr.ack ? ST_EDH : ST_EDL;
      ST_EDH:  state_d = wr.ack ? ST_CMD : ST_EDH;
      ST_CMD:
      begin
        cnt_d = 4'h0;
        if (wr.ack)
        begin
          state_d = ST_SETTLE;
        end
      end
      // Busy may lag the command write; trusting it at once would end early
      ST_SETTLE:
      begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == dfc_pkg::SETTLE_CYC - 4'h1)
        begin
          state_d = ST_POLL;
        end
      end
      ST_POLL:
      begin
        if (!dev_seq_busy_i)
        begin
          done_d  = 1'b1;
          fail_d  = dev_seq_err_i;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      start_q <= 24'h000000;
      end_q   <= 24'h000000;
      op_q    <= 1'b0;
      armed_q <= 1'b0;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
      err_q   <= dfc_pkg::ERR_NONE;
      cnt_q   <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      start_q <= start_d;
      end_q   <= end_d;
      op_q    <= op_d;
      armed_q <= armed_d;
      done_q  <= done_d;
      fail_q  <= fail_d;
      err_q   <= err_d;
      cnt_q   <= cnt_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  area_user_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_AREA |-> dev_wdata_o[dfc_pkg::AREA_SEL_BIT] == 1'b0)
    else $error("area select not cleared");
  addr_high_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_APH |-> dev_wdata_o == {8'h00, start_q[23:16]})
    else $error("address pointer high wrong");
  end_low_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_EDL |-> dev_wdata_o == end_q[15:0])
    else $error("end address low wrong");
  end_high_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_EDH
    |-> dev_wdata_o[15:8] == 8'h00 && end_q - start_q == {8'h00, len_reg})
    else $error("end address not start plus length");
  blank_cmd_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_CMD && !op_q |-> dev_wdata_o == 16'h008B)
    else $error("blank check command wrong");
  verify_cmd_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_CMD && op_q |-> dev_wdata_o == 16'h008A)
    else $error("verify command wrong");
  cmd_order_a: assert property (
    dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_EDH |=> ##1 dev_wr_o && dev_addr_o == dfc_pkg::DEV_IDX_CMD)
    else $error("command not after end address");
  refuse_off_a: assert property (
    state_q == ST_CHECK && !dflash_access_en_i |=> state_q == ST_IDLE && err_q == dfc_pkg::ERR_DISABLED)
    else $error("launch not refused with access off");
  refuse_busy_a: assert property (
    state_q == ST_CHECK && dflash_access_en_i && dev_prog_mode_i && (dev_seq_busy_i || dev_extra_busy_i)
    |=> state_q == ST_IDLE && err_q == dfc_pkg::ERR_BUSY)
    else $error("launch not refused while busy");
  verify_once_a: assert property (
    state_q == ST_CHECK && op_q && !armed_q |=> err_q != dfc_pkg::ERR_NONE && !dev_wr_o [*3])
    else $error("second verify not refused");
  end_wait_a: assert property (
    state_q == ST_POLL && !dev_seq_busy_i |=> done_q && state_q == ST_IDLE)
    else $error("done not reported after busy fell");
  no_early_done_a: assert property (
    state_q == ST_POLL && dev_seq_busy_i |=> state_q == ST_POLL)
    else $error("left poll while device busy");

endmodule
`default_nettype wire

// file: bench/dfc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dfc_dev_model #(
  parameter int BUSY_CYC = 12 // Sequencer run time
) (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_n_i, // Sync reset
  input  wire logic        wr_i,    // Register write strobe
  input  wire logic [2:0]  addr_i,  // Register index
  input  wire logic [15:0] wdata_i, // Write data
  input  wire logic        hold_i,  // Bench keeps it busy
  output logic             busy_o,  // Sequencer busy
  output logic [7:0]       area_o,  // area_select_reg
  output logic [23:0]      ptr_o,   // Address pointer
  output logic [23:0]      end_o,   // End address
  output logic [7:0]       cmd_o,   // seq_command_reg
  output logic [7:0]       nwr_o    // Writes taken
);
  logic [7:0] cnt_q;

  // Register file; a launch bit starts the run
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      {ptr_o, end_o, cmd_o, nwr_o, cnt_q} <= '0;
      area_o <= 8'hFF; // Not the user area, so a missing write shows
    end
    else
    begin
      if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
      if (wr_i)
      begin
        nwr_o <= nwr_o + 8'h01;
        case (addr_i)
          3'h0: area_o <= wdata_i[7:0];
          3'h1: ptr_o[15:0] <= wdata_i;
          3'h2: ptr_o[23:16] <= wdata_i[7:0];
          3'h3: end_o[15:0] <= wdata_i;
          3'h4: end_o[23:16] <= wdata_i[7:0];
          3'h5:
          begin
            cmd_o <= wdata_i[7:0];
            if (wdata_i[7])
              cnt_q <= 8'(BUSY_CYC);
          end
          default: ;
        endcase
      end
    end
  end

  // Busy from launch until the count runs out
  assign busy_o = hold_i || (cnt_q != 8'h00);
endmodule
`default_nettype wire

// file: bench/dfc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module dfc_ctrl_test;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        acc_en = 1'b1;
  logic        prog = 1'b1;
  logic        hold = 1'b0;
  logic        xbusy = 1'b0;
  logic        err = 1'b0;
  logic [31:0] rdat, d, st;
  logic        wait_o, dwr, sbusy;
  logic [2:0]  dadr;
  logic [15:0] dwd, len;
  logic [7:0]  area, cmd, nwr;
  logic [23:0] ptr, eadr;
  logic [31:0] q[$];
  integer      seed = 32'hA92F4DD7;
  int          n_errors = 0;
  int          check_count = 0;

  always #25 clk_i = ~clk_i;

  dfc_ctrl i_dfc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .dev_wr_o(dwr), .dev_addr_o(dadr), .dev_wdata_o(dwd), .dflash_access_en_i(acc_en),
    .dev_prog_mode_i(prog), .dev_seq_busy_i(sbusy), .dev_extra_busy_i(xbusy), .dev_seq_err_i(err));

  dfc_dev_model i_dfc_dev_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(dwr), .addr_i(dadr),
    .wdata_i(dwd), .hold_i(hold), .busy_o(sbusy), .area_o(area), .ptr_o(ptr), .end_o(eadr),
    .cmd_o(cmd), .nwr_o(nwr));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Read whose expected value goes to the monitor's queue
  task automatic exp_rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    av(1'b0, a, 32'h0);
  endtask

  // Clear status, launch, poll until done
  task automatic run(input logic [31:0] c);
    av(1'b1, 4'h4, 32'h0);
    av(1'b1, 4'h0, c);
    do av(1'b0, 4'h4, 32'h0); while (d[1] !== 1'b1);
  endtask

  // Monitor: compare each expected read at its answer edge
  always @(posedge clk_i)
  begin
    if (rd && wait_o === 1'b0 && q.size() != 0)
      chk(rdat, q.pop_front());
  end

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond ten launches
  initial
  begin
    repeat (8000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Random range inside one block, junk in the top byte
    st = $random(seed);
    st[23:0] = {9'h020, st[14:10], 1'b0, st[8:0]};
    len = {7'h00, 9'($random(seed))} + 16'h0001;
    av(1'b1, 4'h8, st);
    av(1'b1, 4'hC, {16'h0, len});
    exp_rd(4'h2, 32'h0);
    run(32'h1);
    exp_rd(4'h4, 32'h2);
    chk({24'h0, area}, 32'h0);
    chk({8'h0, ptr}, {8'h0, st[23:0]});
    chk({8'h0, eadr}, {8'h0, st[23:0] + 24'(len)});
    chk({24'h0, cmd}, 32'h8B);
    run(32'h3);
    exp_rd(4'h4, 32'h56);
    av(1'b1, 4'h0, 32'h4);
    exp_rd(4'h4, 32'h156);
    err <= 1'b1;
    run(32'h3);
    exp_rd(4'h4, 32'hA);
    chk({24'h0, cmd}, 32'h8A);
    chk({8'h0, eadr}, {8'h0, st[23:0] + 24'(len)});
    run(32'h3);
    exp_rd(4'h4, 32'h56);
    err <= 1'b0;
    // Each precondition broken in turn
    for (int i = 0; i < 4; i++)
    begin
      acc_en <= (i != 0);
      prog <= (i != 1);
      hold <= (i == 2);
      xbusy <= (i == 3);
      run(32'h1);
      exp_rd(4'h4, 32'h6 | ((i < 2 ? i + 1 : 3) << 4));
    end
    {acc_en, prog, hold, xbusy} <= 4'hC;
    // Block straddle, then start below the data flash
    av(1'b1, 4'h8, 32'h001003FF);
    av(1'b1, 4'hC, 32'h2);
    run(32'h1);
    exp_rd(4'h4, 32'h46);
    av(1'b1, 4'h8, 32'h000FFFFF);
    run(32'h1);
    exp_rd(4'h4, 32'h46);
    chk({24'h0, nwr}, 32'hC);
    @(posedge clk_i);
    end_sim();
  end
endmodule
`default_nettype wire
